//--- shared/iox_defs.vh
/*
 Constants of the I2C eight-bit I/O expander core: bus address, register
 pointer codes, reset values and bit counts. Included by the core and the testbench.
*/
`ifndef IOX_DEFS_VH
`define IOX_DEFS_VH
`define IOX_ADDR_FIXED 5'h1C
`define IOX_PTR_INPUT 2'h0
`define IOX_PTR_OUTPUT 2'h1
`define IOX_PTR_POLARITY 2'h2
`define IOX_PTR_DIRECTION 2'h3
`define IOX_RST_OUTPUT 8'hFF
`define IOX_RST_POLARITY 8'h00
`define IOX_RST_DIRECTION 8'hFF
`define IOX_RST_POINTER 8'h00
`define IOX_BIT_LAST 4'h7
`define IOX_BIT_ACK 4'h8
`endif

//--- hdl/iox_sync.v
/*
 Two-flip-flop synchroniser for a vector of asynchronous levels.
 Assumes the inputs are static long enough to be sampled by clk_in.
*/
`timescale 1ns/1ps
module iox_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	input wire clk_in,
	input wire resetn_in,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;

	// The first stage is read only by the second stage.
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_q <= INIT;
			sync_out <= INIT;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // iox_sync

//--- hdl/iox_core.v
/*
 I2C slave core of an eight-bit I/O expander: four registers, port pin
 drivers and a change-detect alert. SCL, SDA, pins and address selects are
 oversampled by clk_in, which must run far faster than SCL.
*/
`timescale 1ns/1ps
`include "iox_defs.vh"

////////////////////////////////////////////////////////////////////////////
// Contract
// - Reset input low forces all registers and bus state to defaults.
// - Power-on reset holds the core in reset, then releases to defaults.
// - An input pin has both drivers off.
// - An output pin drives exactly one driver per its output bit.
// - Any edge on an input-mode pin asserts the alert.
// - Alert clears when inputs return to captured values or port is read.
// - Read clear happens after SCL rises on the ack or nack bit.
// - Changes during that ack pulse may be lost or alert briefly.
// - After a clear every later change raises the alert again.
// - Output pins and traffic for other devices never raise the alert.
// - Output to input switch may give a false alert on mismatch.
// - Alert is open-drain active low, only pulled low.
// - With pointer 00h, another slave's read ack wrongly clears alert.
// - Start is SDA fall with SCL high; address goes MSB first.
// - Stop is SDA rise with SCL high and ends the transaction.
// - Matching address is acked by holding SDA low through SCL high.
// - SDA changes only with SCL low; otherwise it is start or stop.
// - Bytes are eight bits plus an ack bit; transmitter releases SDA.
// - Device acks each received byte; master acks reads except last.
// - On master nack the device releases SDA for the stop.
// - Address is 11100 plus two select pins; last bit 1 reads.
// - First written byte sets the pointer; it persists for reads.
// - Direction bit 1 is input, 0 is output; resets to all ones.
// - Polarity bit 1 inverts the input reading; resets to zero.
module iox_core (
	input wire clk_in,
	input wire resetn_in,
	input wire por_done_in,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_out,
	input wire addr_select_lo_in,
	input wire addr_select_hi_in,
	input wire [7:0] expander_pins_in,
	output reg [7:0] expander_pins_out,
	output reg [7:0] expander_pins_oe_out,
	output reg [7:0] high_side_driver_out,
	output reg [7:0] low_side_driver_out,
	output reg alert_out,
	output reg alert_oe_out
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_PTR = 3'h2;
	localparam [2:0] ST_WDATA = 3'h3;
	localparam [2:0] ST_RDATA = 3'h4;
	localparam [2:0] ST_SKIP = 3'h5;

	wire rst_n;
	wire scl_s;
	wire sda_s;
	wire [1:0] sel_s;
	wire [7:0] pins_s;
	reg scl_q;
	reg sda_q;
	reg [2:0] state_q;
	reg [3:0] bit_q;
	reg [7:0] shift_q;
	reg ack_q;
	reg slot_q;
	reg rd_q;
	reg [7:0] pointer_q;
	reg [7:0] output_q;
	reg [7:0] polarity_q;
	reg [7:0] direction_q;
	reg [7:0] captured_q;
	reg [7:0] txbyte_q;
	reg seen_q;
	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;
	wire [7:0] input_view;
	wire [7:0] changed;
	wire read_clear;
	wire foreign_clear;

	// Power-on reset is merged with the pin reset; both clear everything.
	assign rst_n = resetn_in & por_done_in;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers. The bus idles high, so its lines start high.
	iox_sync #(.WIDTH(2), .INIT(2'h3)) u_bus_sync (
		.clk_in(clk_in),
		.resetn_in(rst_n),
		.async_in({scl_in, sda_in}),
		.sync_out({scl_s, sda_s})
	);

	iox_sync #(.WIDTH(10), .INIT(10'h000)) u_pin_sync (
		.clk_in(clk_in),
		.resetn_in(rst_n),
		.async_in({addr_select_hi_in, addr_select_lo_in, expander_pins_in}),
		.sync_out({sel_s, pins_s})
	);

	// Delayed copies of the synchronised bus lines for edge detection.
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	// SDA moving while SCL is high is always a bus condition.
	assign start_det = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

	// Input register view, with per-bit polarity inversion.
	assign input_view = pins_s ^ polarity_q;

	////////////////////////////////////////////////////////////////////////
	// Protocol engine. Bits are sampled on SCL rise and driven on SCL fall;
	// bit count 8 is the ack slot of each byte.
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			ack_q <= 1'b0;
			slot_q <= 1'b0;
			rd_q <= 1'b0;
			pointer_q <= `IOX_RST_POINTER;
			output_q <= `IOX_RST_OUTPUT;
			polarity_q <= `IOX_RST_POLARITY;
			direction_q <= `IOX_RST_DIRECTION;
			txbyte_q <= 8'h00;
			sda_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end else if (start_det) begin
			state_q <= ST_ADDR;
			bit_q <= 4'h0;
			ack_q <= 1'b0;
			slot_q <= 1'b0;
			sda_oe_out <= 1'b0;
		end else if (stop_det) begin
			state_q <= ST_IDLE;
			sda_oe_out <= 1'b0;
		end else if (state_q != ST_IDLE) begin
			if (scl_rise) begin
				if (bit_q != `IOX_BIT_ACK) begin
					// A read shifts out on falls only, so it must not
					// shift here as well or every other bit is skipped.
					if (state_q != ST_RDATA) begin
						shift_q <= {shift_q[6:0], sda_s};
					end
					bit_q <= bit_q + 4'h1;
				end else begin
					// Master nack during a read ends our transmission.
					ack_q <= ~sda_s;
					slot_q <= 1'b1;
				end
			end else if (scl_fall) begin
				if (bit_q == `IOX_BIT_ACK && !sda_oe_out && state_q != ST_RDATA) begin
					// Byte done: decide on acknowledging it.
					case (state_q)
						ST_ADDR: begin
							if (shift_q[7:3] == `IOX_ADDR_FIXED && shift_q[2:1] == sel_s) begin
								sda_oe_out <= 1'b1;
								rd_q <= shift_q[0];
							end else begin
								state_q <= ST_SKIP;
							end
						end
						ST_PTR: begin
							pointer_q <= shift_q;
							sda_oe_out <= 1'b1;
						end
						ST_WDATA: begin
							case (pointer_q[1:0])
								`IOX_PTR_OUTPUT: output_q <= shift_q;
								`IOX_PTR_POLARITY: polarity_q <= shift_q;
								`IOX_PTR_DIRECTION: direction_q <= shift_q;
								default: ;
							endcase
							sda_oe_out <= 1'b1;
						end
						default: ;
					endcase
					sda_out <= 1'b0;
				end else if (bit_q == `IOX_BIT_ACK &&
					state_q == ST_RDATA && !slot_q) begin
					// Ack slot opens: the master owns SDA now.
					sda_oe_out <= 1'b0;
				end else if (bit_q == `IOX_BIT_ACK &&
					state_q == ST_RDATA && !ack_q) begin
					// Master nacked: stay released until stop or restart.
					state_q <= ST_SKIP;
				end else if (bit_q == `IOX_BIT_ACK) begin
					// End of ack slot: release SDA, or drive the first read bit, and move on.
					bit_q <= 4'h0;
					ack_q <= 1'b0;
					slot_q <= 1'b0;
					if (state_q == ST_ADDR) begin
						state_q <= rd_q ? ST_RDATA : ST_PTR;
					end else if (state_q == ST_PTR) begin
						state_q <= ST_WDATA;
					end
					if ((state_q == ST_ADDR && rd_q) || state_q == ST_RDATA) begin
						sda_oe_out <= ~txbyte_q[7];
						sda_out <= 1'b0;
						shift_q <= {txbyte_q[6:0], 1'b0};
					end else begin
						sda_oe_out <= 1'b0;
					end
				end else if (state_q == ST_RDATA) begin
					// Next data bit, MSB first, up to the last bit.
					sda_oe_out <= ~shift_q[7];
					shift_q <= {shift_q[6:0], 1'b0};
				end
			end
			// Load the next read byte at the ack slot rising edge.
			if (scl_rise && bit_q == `IOX_BIT_ACK) begin
				case (pointer_q[1:0])
					`IOX_PTR_INPUT: txbyte_q <= input_view;
					`IOX_PTR_OUTPUT: txbyte_q <= output_q;
					`IOX_PTR_POLARITY: txbyte_q <= polarity_q;
					default: txbyte_q <= direction_q;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Change detection. Only input-mode bits compare against the capture,
	// so outputs never alert; a direction flip to input may alert falsely.
	assign changed = (pins_s ^ captured_q) & direction_q;

	// Clear on the ack-slot SCL rise of a read from this device. The
	// capture is refreshed there, so a change in that pulse can be lost.
	assign read_clear = scl_rise && bit_q == `IOX_BIT_ACK && rd_q &&
		(state_q == ST_RDATA || state_q == ST_ADDR);

	// Faithful defect: with pointer 00h a read acked by another slave also
	// refreshes the capture, silently clearing a pending alert.
	assign foreign_clear = scl_rise && bit_q == `IOX_BIT_ACK &&
		state_q == ST_SKIP && shift_q[0] && !sda_s &&
		pointer_q == 8'h00 && !seen_q;

	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			captured_q <= 8'h00;
			seen_q <= 1'b0;
		end else begin
			if (read_clear || foreign_clear) begin
				captured_q <= pins_s;
			end
			if (start_det) begin
				seen_q <= 1'b0;
			end else if (scl_rise && bit_q == `IOX_BIT_ACK) begin
				// Marked after the ack rise so that rise itself still counts.
				seen_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered pin and alert outputs.
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			expander_pins_out <= 8'h00;
			expander_pins_oe_out <= 8'h00;
			high_side_driver_out <= 8'h00;
			low_side_driver_out <= 8'h00;
			alert_out <= 1'b0;
			alert_oe_out <= 1'b0;
		end else begin
			expander_pins_out <= output_q;
			expander_pins_oe_out <= ~direction_q;
			high_side_driver_out <= ~direction_q & output_q;
			low_side_driver_out <= ~direction_q & ~output_q;
			alert_out <= 1'b0;
			alert_oe_out <= |changed;
		end
	end
endmodule // iox_core

//--- verif/iox_master.sv
/*
 I2C master model: drives SCL and pulls SDA low.
 Assumes the bench builds the pulled-up SDA wire.
*/
`timescale 1ns/1ps
module iox_master (
	input wire sda_in,
	output reg scl_out,
	output reg sda_low_out
);
// SCL stands still high and SDA is released outside frames.
initial begin
	scl_out = 1'b1;
	sda_low_out = 1'b0;
end
////////////////////////////////////////////////////////////////////////////
// A start from idle and a repeated start take the same path.
task start; begin
	#12 sda_low_out = 1'b0;
	#12 scl_out = 1'b1;
	#12 sda_low_out = 1'b1;
	#12 scl_out = 1'b0;
end endtask
// Release SDA while SCL is high to close the frame.
task stop; begin
	#12 sda_low_out = 1'b1;
	#12 scl_out = 1'b1;
	#12 sda_low_out = 1'b0;
	#24;
end endtask
// Data moves only in the low phase; SDA is read mid-high.
task bit_io(input logic b, output logic r); begin
	#12 sda_low_out = !b;
	#12 scl_out = 1'b1;
	#12 r = sda_in;
	#12 scl_out = 1'b0;
end endtask
// Eight bits MSB first, then the acknowledge slot.
task xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
	output logic ack); begin
	for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
	bit_io(last, ack);
	ack = !ack;
end endtask
endmodule // iox_master

//--- verif/iox_core_sva_sva.sv
/*
 Port assertions of the expander core.
 Assumes clk_in runs far faster than SCL.
*/
`timescale 1ns/1ps
module iox_core_sva (
	input wire clk_in,
	input wire resetn_in,
	input wire por_done_in,
	input wire scl_in,
	input wire [7:0] expander_pins_in,
	input wire sda_oe_out,
	input wire [7:0] expander_pins_out,
	input wire [7:0] expander_pins_oe_out,
	input wire [7:0] high_side_driver_out,
	input wire [7:0] low_side_driver_out,
	input wire alert_out,
	input wire alert_oe_out
);
default clocking @(posedge clk_in); endclocking
default disable iff (!resetn_in || !por_done_in);
logic [16:0] last_q;
logic [3:0] quiet_q;
wire [16:0] now_w = {scl_in, expander_pins_in, expander_pins_oe_out};
////////////////////////////////////////////////////////////////////////////
// Counts quiet cycles; the alert has no cause to move in them.
always_ff @(posedge clk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		last_q <= 17'h00000;
		quiet_q <= 4'h0;
	end else begin
		last_q <= now_w;
		if (!por_done_in || last_q != now_w) quiet_q <= 4'h0;
		else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
	end
end
AST_HI: assert property (high_side_driver_out ==
	(expander_pins_out & expander_pins_oe_out)) else $error("high drive");
AST_LO: assert property (low_side_driver_out ==
	(~expander_pins_out & expander_pins_oe_out)) else $error("low drive");
AST_INT_LOW: assert property (alert_out == 1'b0)
	else $error("alert drives high");
AST_RST: assert property ($rose(resetn_in) |-> !sda_oe_out &&
	!alert_oe_out && expander_pins_oe_out == 8'h00) else $error("reset");
AST_SDA_SCL: assert property ($changed(sda_oe_out) |->
	!scl_in && !$past(scl_in, 2)) else $error("sda moved in high");
AST_ACK_HOLD: assert property ($rose(scl_in) && sda_oe_out |->
	sda_oe_out[*8]) else $error("ack not held");
AST_QUIET: assert property (quiet_q >= 4'h8 |->
	$stable(alert_oe_out)) else $error("alert moved alone");
AST_OUT_NO_INT: assert property (&expander_pins_oe_out &&
	$past(expander_pins_oe_out, 4) == 8'hFF |-> !$rose(alert_oe_out))
	else $error("output raised alert");
// Main scenarios seen at least once.
COV_ACK: cover property ($rose(sda_oe_out));
COV_INT: cover property ($rose(alert_oe_out));
COV_CLR: cover property ($fell(alert_oe_out));
endmodule // iox_core_sva
bind iox_core iox_core_sva u_sva (.*);

//--- verif/tb_iox_core.sv
/*
 Self-checking bench of the expander core against a bench model.
 Assumes pins read back the driven level where they are outputs.
*/
`timescale 1ns/1ps
`include "iox_defs.vh"
module tb_iox_core;
logic clk_in = 1'b0, resetn_in = 1'b0, por_done_in = 1'b0;
logic sl = 1'b0, sh = 1'b0, ack;
logic [7:0] pins = 8'h00, m_out = 8'hFF, m_pol = 8'h00, m_dir = 8'hFF;
logic [7:0] m_cap = 8'h00, q, v;
wire scl, m_low, soe, aoe;
wire [7:0] po, poe, hi, lo;
wire sda = !(m_low || soe);
wire [7:0] lvl = (poe & po) | (~poe & pins);
int err_total = 0, checks_done = 0, cyc = 0;
iox_core i_iox_core (.clk_in(clk_in), .resetn_in(resetn_in),
	.por_done_in(por_done_in), .scl_in(scl), .sda_in(sda), .sda_out(),
	.sda_oe_out(soe), .addr_select_lo_in(sl), .addr_select_hi_in(sh),
	.expander_pins_in(lvl), .expander_pins_out(po),
	.expander_pins_oe_out(poe), .high_side_driver_out(hi),
	.low_side_driver_out(lo), .alert_out(), .alert_oe_out(aoe));
iox_master u_m (.sda_in(sda), .scl_out(scl), .sda_low_out(m_low));
////////////////////////////////////////////////////////////////////////////
task chk(input string n, input logic [7:0] s, e); begin
	checks_done++;
	if (s !== e) begin
		err_total++;
		$display("unexpected %s expected %h seen %h", n, e, s);
	end
end endtask
task tally_and_finish; begin
	$display("checks %0d errors %0d", checks_done, err_total);
	if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
	else $display("[ FAIL ]");
	$finish;
end endtask
// Alert waits out synchroniser latency before the compare.
task setp(input logic [7:0] d); begin
	@(posedge clk_in);
	#1 pins = d;
	repeat (12) @(posedge clk_in);
	chk("alert", aoe, {7'h00, |((lvl ^ m_cap) & m_dir)});
end endtask
task addr(input logic r); begin
	u_m.start;
	u_m.xfer({`IOX_ADDR_FIXED, sh, sl, r}, 1'b1, q, ack);
	chk("addr ack", ack, 1'b1);
end endtask
// Pointer write with an optional data byte; the model follows.
task wr(input logic [1:0] p, input logic [7:0] d, input logic nd); begin
	addr(1'b0);
	u_m.xfer({6'h00, p}, 1'b1, q, ack);
	chk("ptr ack", ack, 1'b1);
	if (nd) u_m.xfer(d, 1'b1, q, ack);
	chk("data ack", ack, 1'b1);
	u_m.stop;
	if (nd && p == `IOX_PTR_OUTPUT) m_out = d;
	if (nd && p == `IOX_PTR_POLARITY) m_pol = d;
	if (nd && p == `IOX_PTR_DIRECTION) m_dir = d;
	chk("oe", poe, ~m_dir);
	chk("high", hi, ~m_dir & m_out);
	chk("low", lo, ~m_dir & ~m_out);
end endtask
// Input reads; the last byte is refused so the device lets go.
task rd(input int n); begin
	wr(`IOX_PTR_INPUT, 8'h00, 1'b0);
	addr(1'b1);
	for (int k = 0; k < n; k++) begin
		u_m.xfer(8'hFF, k == n - 1, q, ack);
		chk("read", q, lvl ^ m_pol);
	end
	chk("release", soe, 1'b0);
	u_m.stop;
	m_cap = lvl;
	wr(`IOX_PTR_OUTPUT, 8'h00, 1'b0);
	setp(pins);
end endtask
////////////////////////////////////////////////////////////////////////////
initial forever #2 clk_in = ~clk_in;
// A hang counts as a mismatch.
always @(posedge clk_in) begin
	cyc <= cyc + 1;
	if (cyc == 30000) begin
		err_total++;
		tally_and_finish;
	end
end
initial begin
	void'($urandom(32'hD271));
	{sh, sl} = 2'($urandom_range(3));
	repeat (8) @(posedge clk_in);
	#1 resetn_in = 1'b1;
	por_done_in = 1'b1;
	repeat (8) @(posedge clk_in);
	chk("oe", poe, 8'h00);
	chk("drv", hi | lo, 8'h00);
	v = 8'($urandom_range(255, 1));
	setp(v);
	setp(8'h00);
	setp(v);
	rd(2);
	u_m.start;
	u_m.xfer({`IOX_ADDR_FIXED, ~sh, sl, 1'b1}, 1'b1, q, ack);
	chk("other ack", ack, 1'b0);
	u_m.stop;
	setp(pins);
	// Pointer 00h, then another slave acks a read address: capture refreshes.
	wr(`IOX_PTR_INPUT, 8'h00, 1'b0);
	setp(~pins);
	u_m.start;
	u_m.xfer({`IOX_ADDR_FIXED, ~sh, sl, 1'b1}, 1'b0, q, ack);
	u_m.stop;
	m_cap = lvl;
	setp(pins);
	for (int k = 0; k < 8; k++) begin
		wr(2'(k), 8'($urandom), 1'b1);
		setp(8'($urandom));
	end
	wr(`IOX_PTR_DIRECTION, 8'h00, 1'b1);
	setp(8'($urandom));
	wr(`IOX_PTR_DIRECTION, 8'hFF, 1'b1);
	setp(8'($urandom));
	rd(1);
	tally_and_finish;
end
endmodule // tb_iox_core
